/* core/srec_core.sv */
// Purpose: Scan, exposure and readout sequencing with its control registers
// Assumes: Pixel data arrive on pixel_i in step with the active rows
// Notes:   Row timing is one shared row tick; readout and free-running exposure starts align to it

`timescale 1ns/1ns

module srec_core
    import srec_pkg::*;
#(
    parameter int unsigned ROW_CYCLES  = 846,
    parameter int unsigned ACTIVE_ROWS = 480,
    parameter int unsigned VBLANK_ROWS = 45,
    parameter logic [8:0]  ROW_START   = 9'h004
)(
    input  wire logic        ref_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    input  wire logic        trig_i,
    input  wire logic [9:0]  pixel_i,
    output logic      [9:0]  pix_o,
    output logic             pix_oe_n_o,
    output logic      [8:0]  row_addr_o,
    output logic             frame_start_o,
    output logic             frame_valid_o,
    output logic             exposing_o,
    output logic      [1:0]  knee_phase_o,
    output logic      [4:0]  pll_mult_o,
    output logic             stereo_slave_o
);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [15:0] ctrl_ff, knee1_ff, knee2_ff, ratio_ff, total_ff, hdr_ff, rdata_ff;
    srec_ctrl_s  sh_ff;
    logic [15:0] status;

    wire logic wr_ctrl  = wr_i && addr_i == ADDR_CTRL;
    wire logic wr_knee1 = wr_i && addr_i == ADDR_KNEE1;
    wire logic wr_knee2 = wr_i && addr_i == ADDR_KNEE2;
    wire logic wr_ratio = wr_i && addr_i == ADDR_RATIO;
    wire logic wr_total = wr_i && addr_i == ADDR_TOTAL;
    wire logic wr_hdr   = wr_i && addr_i == ADDR_HDR;

    wire logic [15:0] rd_mux =
        (addr_i == ADDR_CTRL)   ? ctrl_ff  :
        (addr_i == ADDR_KNEE1)  ? knee1_ff :
        (addr_i == ADDR_KNEE2)  ? knee2_ff :
        (addr_i == ADDR_RATIO)  ? ratio_ff :
        (addr_i == ADDR_TOTAL)  ? total_ff :
        (addr_i == ADDR_HDR)    ? hdr_ff   :
        (addr_i == ADDR_STATUS) ? status   : 16'h0000;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_ff  <= RST_CTRL;
            knee1_ff <= RST_KNEE1;
            knee2_ff <= RST_KNEE2;
            ratio_ff <= RST_RATIO;
            total_ff <= RST_TOTAL;
            hdr_ff   <= RST_HDR;
        end else begin
            if (wr_ctrl)  ctrl_ff  <= wdata_i & MSK_CTRL;
            if (wr_knee1) knee1_ff <= wdata_i & MSK_ROW;
            if (wr_knee2) knee2_ff <= wdata_i & MSK_ROW;
            if (wr_ratio) ratio_ff <= wdata_i & MSK_RATIO;
            if (wr_total) total_ff <= wdata_i & MSK_ROW;
            if (wr_hdr)   hdr_ff   <= wdata_i & MSK_HDR;
        end
    end

    // Read data only in the cycle after the strobe
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) rdata_ff <= 16'h0000;
        else           rdata_ff <= rd_i ? rd_mux : 16'h0000;
    end
    assign rdata_o = rdata_ff;

    // ------------------------------------------------------------
    // Row tick and trigger
    // ------------------------------------------------------------
    logic [15:0] row_cyc_ff;
    logic        trig_d_ff, trig_pend_ff;
    wire  logic  row_tick  = row_cyc_ff == 16'(ROW_CYCLES - 1);
    wire  logic  trig_rise = trig_i && !trig_d_ff;
    wire  logic  trig_fall = !trig_i && trig_d_ff;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) row_cyc_ff <= 16'h0000;
        else           row_cyc_ff <= row_tick ? 16'h0000 : row_cyc_ff + 16'h0001;
    end

    // ------------------------------------------------------------
    // Exposure engine
    // ------------------------------------------------------------
    srec_ex_e    ex_ff;
    srec_rd_e    rd_ff;
    logic [14:0] ex_row_ff, ex_total_ff;
    logic        ex_ready_ff;
    srec_knee_s  knee;

    wire logic rd_idle  = rd_ff == RD_IDLE;
    wire logic ex_idle  = ex_ff == EX_IDLE;
    // Free-running only in master mode without snapshot
    wire logic free_run = sh_ff.master && !sh_ff.snapshot;
    wire logic slot_ok  = ex_idle && !ex_ready_ff && (sh_ff.simul || rd_idle);
    wire logic ex_start = slot_ok && (free_run ? row_tick : trig_pend_ff);
    wire logic [14:0] tot_eff = (total_ff == 15'h0000) ? 15'h0001 : total_ff[14:0];
    wire logic ex_end_m = ex_ff == EX_RUN && sh_ff.master && row_tick
                          && ex_row_ff == ex_total_ff - 15'h0001;
    // Slave exposure lasts while the trigger stays high
    wire logic ex_end_s = ex_ff == EX_RUN && !sh_ff.master && trig_fall;
    wire logic ex_end   = ex_end_m || ex_end_s;
    wire logic rd_start = rd_idle && ex_ready_ff && row_tick;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trig_d_ff    <= 1'b0;
            trig_pend_ff <= 1'b0;
        end else begin
            trig_d_ff    <= trig_i;
            // A pulse that lands on the consuming cycle is kept
            trig_pend_ff <= trig_rise || (trig_pend_ff && !ex_start);
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ex_ff       <= EX_IDLE;
            ex_row_ff   <= 15'h0000;
            ex_total_ff <= 15'h0001;
            ex_ready_ff <= 1'b0;
        end else begin
            ex_ready_ff <= ex_end || (ex_ready_ff && !rd_start);
            case (ex_ff)
                EX_IDLE: begin
                    if (ex_start) begin
                        ex_ff       <= EX_RUN;
                        ex_row_ff   <= 15'h0000;
                        ex_total_ff <= tot_eff;
                    end
                end
                EX_RUN: begin
                    if (ex_end) ex_ff <= EX_IDLE;
                    else if (row_tick) ex_row_ff <= ex_row_ff + 15'h0001;
                end
                default: ex_ff <= EX_IDLE;
            endcase
        end
    end

    srec_knee_calc u_knee (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .load_i    (ex_start),
        .hdr_i     (hdr_ff[HDR_EN_BIT]),
        .auto_i    (ratio_ff[AUTO_BIT]),
        .sw1_i     (knee1_ff[14:0]),
        .sw2_i     (knee2_ff[14:0]),
        .total_i   (tot_eff),
        .r2_i      (ratio_ff[3:0]),
        .r3_i      (ratio_ff[7:4]),
        .knee_o    (knee)
    );

    wire logic [15:0] knee12 = {1'b0, knee.t1} + {1'b0, knee.t2};
    assign knee_phase_o = (ex_ff != EX_RUN || !hdr_ff[HDR_EN_BIT]) ? 2'h0 :
                          ({1'b0, ex_row_ff} < {1'b0, knee.t1}) ? 2'h1 :
                          ({1'b0, ex_row_ff} < knee12)          ? 2'h2 : 2'h3;
    assign exposing_o   = ex_ff == EX_RUN;

    // ------------------------------------------------------------
    // Readout engine
    // ------------------------------------------------------------
    logic [8:0]  idx_ff;
    logic [15:0] rd_row_ff;
    logic        field_ff, fs_ff;
    wire  logic  sh_load  = rd_start || (rd_idle && ex_idle && !ex_ready_ff);
    wire  logic  two_fld  = sh_ff.scan == SCAN_TWO;
    wire  logic  one_fld  = sh_ff.scan == SCAN_ONE;
    wire  logic  step2    = two_fld || one_fld;
    wire  logic [9:0] idx_nx = {1'b0, idx_ff} + (step2 ? 10'h002 : 10'h001);
    wire  logic  fld_end  = idx_nx >= 10'(ACTIVE_ROWS);
    // Scan value 1 is invalid and falls back to progressive order
    wire  logic  act_done = fld_end && !(two_fld && !field_ff);

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sh_ff <= srec_ctrl_s'(RST_CTRL);
        end else if (sh_load) begin
            sh_ff <= srec_ctrl_s'(ctrl_ff);
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_ff     <= RD_IDLE;
            rd_row_ff <= 16'h0000;
            idx_ff    <= 9'h000;
            field_ff  <= 1'b0;
            fs_ff     <= 1'b0;
        end else begin
            fs_ff <= rd_start;
            case (rd_ff)
                RD_IDLE: begin
                    if (rd_start) begin
                        rd_ff     <= RD_DARK;
                        rd_row_ff <= 16'h0000;
                    end
                end
                RD_DARK: begin
                    if (row_tick) begin
                        rd_row_ff <= rd_row_ff + 16'h0001;
                        if (rd_row_ff == 16'(DARK_ROWS - 3'h1)) begin
                            rd_ff    <= RD_ACT;
                            idx_ff   <= 9'h000;
                            field_ff <= 1'b0;
                        end
                    end
                end
                RD_ACT: begin
                    if (row_tick) begin
                        if (act_done) begin
                            rd_ff     <= RD_BLANK;
                            rd_row_ff <= 16'h0000;
                        end else if (fld_end) begin
                            idx_ff   <= 9'h001;
                            field_ff <= 1'b1;
                        end else begin
                            idx_ff <= idx_nx[8:0];
                        end
                    end
                end
                RD_BLANK: begin
                    if (row_tick) begin
                        rd_row_ff <= rd_row_ff + 16'h0001;
                        if (rd_row_ff >= 16'(VBLANK_ROWS - 1)) rd_ff <= RD_IDLE;
                    end
                end
                default: rd_ff <= RD_IDLE;
            endcase
        end
    end

    assign frame_start_o = fs_ff;
    assign frame_valid_o = rd_ff == RD_ACT;
    assign row_addr_o    = ROW_START + idx_ff;

    // ------------------------------------------------------------
    // Pixel outputs and clocking mode
    // ------------------------------------------------------------
    logic [9:0] pix_ff;
    logic [4:0] mult_ff;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pix_ff  <= 10'h000;
            mult_ff <= MULT_SOLO;
        end else begin
            pix_ff  <= frame_valid_o ? pixel_i : 10'h000;
            mult_ff <= sh_ff.stereo ? MULT_STEREO : MULT_SOLO;
        end
    end
    assign pix_o          = pix_ff;
    assign pix_oe_n_o     = !sh_ff.par_oe;
    assign pll_mult_o     = mult_ff;
    // Role only meaningful with stereo on
    assign stereo_slave_o = sh_ff.stereo && sh_ff.stereo_slave;

    assign status = {9'h000, ex_ready_ff, exposing_o, frame_valid_o, ~rd_idle,
                     field_ff, knee_phase_o};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_prog_step: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        rd_ff == RD_ACT && row_tick && sh_ff.scan == SCAN_PROG && !fld_end
        |=> row_addr_o == $past(row_addr_o) + 9'h001)
        else $error("progressive row step wrong");

    a_single_parity: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        frame_valid_o && sh_ff.scan == SCAN_ONE |-> row_addr_o[0] == ROW_START[0])
        else $error("single field parity wrong");

    a_slave_trig: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ex_start && !sh_ff.master |-> trig_pend_ff)
        else $error("slave exposure started without trigger");

    a_snap_trig: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ex_start && sh_ff.snapshot && !trig_rise |=> exposing_o && !trig_pend_ff)
        else $error("snapshot start misbehaved");

    a_pll_mult: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        $rose(sh_ff.stereo) |=> pll_mult_o == MULT_STEREO)
        else $error("clock multiplier wrong");

    a_pix_float: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        !ctrl_ff[7] && sh_load |=> pix_oe_n_o)
        else $error("pixel outputs not floated");

    a_seq_order: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ex_start && !sh_ff.simul |-> rd_idle)
        else $error("sequential exposure overlapped readout");

    a_seq_overlap: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        frame_valid_o && !sh_ff.simul |-> !exposing_o)
        else $error("sequential readout overlapped exposure");

    a_shadow_load: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        sh_ff != $past(sh_ff) |-> $past(sh_load))
        else $error("shadow changed outside frame start");

    a_rsvd_zero: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        rd_i && addr_i == ADDR_CTRL |=> rdata_o[15:9] == 7'h00)
        else $error("undefined control bits not zero");

    c_two_field: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        rd_ff == RD_ACT && two_fld && fld_end && !field_ff && row_tick);
    c_snapshot: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ex_start && sh_ff.snapshot);
    c_overlap: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        exposing_o && frame_valid_o);

endmodule

/* core/srec_pkg.sv */
// Purpose: Shared constants, types and helpers of the readout and exposure control
// Assumes: 16-bit registers, one aligned word per register index
// Notes:   Byte address of a register is four times its index

package srec_pkg;

    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0]  IDX_CTRL   = 8'h07;
    localparam logic [7:0]  IDX_KNEE1  = 8'h08;
    localparam logic [7:0]  IDX_KNEE2  = 8'h09;
    localparam logic [7:0]  IDX_RATIO  = 8'h0A;
    localparam logic [7:0]  IDX_TOTAL  = 8'h0B;
    localparam logic [7:0]  IDX_HDR    = 8'h0F;
    localparam logic [7:0]  IDX_STATUS = 8'h10;

    localparam logic [7:0]  ADDR_CTRL   = {IDX_CTRL[5:0], 2'b00};
    localparam logic [7:0]  ADDR_KNEE1  = {IDX_KNEE1[5:0], 2'b00};
    localparam logic [7:0]  ADDR_KNEE2  = {IDX_KNEE2[5:0], 2'b00};
    localparam logic [7:0]  ADDR_RATIO  = {IDX_RATIO[5:0], 2'b00};
    localparam logic [7:0]  ADDR_TOTAL  = {IDX_TOTAL[5:0], 2'b00};
    localparam logic [7:0]  ADDR_HDR    = {IDX_HDR[5:0], 2'b00};
    localparam logic [7:0]  ADDR_STATUS = {IDX_STATUS[5:0], 2'b00};

    // ------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [15:0] RST_CTRL  = 16'h0188;
    localparam logic [15:0] RST_KNEE1 = 16'h01BB;
    localparam logic [15:0] RST_KNEE2 = 16'h01D9;
    localparam logic [15:0] RST_RATIO = 16'h0164;
    localparam logic [15:0] RST_TOTAL = 16'h01E0;
    localparam logic [15:0] RST_HDR   = 16'h0000;

    localparam logic [15:0] MSK_CTRL  = 16'h01FF;
    localparam logic [15:0] MSK_ROW   = 16'h7FFF;
    localparam logic [15:0] MSK_RATIO = 16'h03FF;
    localparam logic [15:0] MSK_HDR   = 16'h0040;

    // Field positions
    localparam int unsigned HDR_EN_BIT = 6;
    localparam int unsigned AUTO_BIT   = 8;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [2:0]  SCAN_PROG   = 3'h0;
    localparam logic [2:0]  SCAN_TWO    = 3'h2;
    localparam logic [2:0]  SCAN_ONE    = 3'h3;
    localparam logic [4:0]  MULT_SOLO   = 5'h0C;
    localparam logic [4:0]  MULT_STEREO = 5'h12;
    localparam logic [2:0]  DARK_ROWS   = 3'h4;

    typedef struct packed {
        logic [6:0] rsvd;
        logic       simul;
        logic       par_oe;
        logic       stereo_slave;
        logic       stereo;
        logic       snapshot;
        logic       master;
        logic [2:0] scan;
    } srec_ctrl_s;

    typedef struct packed {
        logic [14:0] t1;
        logic [14:0] t2;
        logic [14:0] t3;
    } srec_knee_s;

    typedef enum logic [1:0] {EX_IDLE, EX_RUN}                   srec_ex_e;
    typedef enum logic [1:0] {RD_IDLE, RD_DARK, RD_ACT, RD_BLANK} srec_rd_e;

    function automatic logic [14:0] sat_sub(input logic [14:0] a, input logic [14:0] b);
        return (a > b) ? (a - b) : 15'h0000;
    endfunction

endpackage

/* core/srec_knee_calc.sv */
// Purpose: Knee interval calculator, latched once per exposure start
// Assumes: load_i is a one-cycle pulse at exposure start
// Notes:   Differences saturate at zero when widths are out of order

`timescale 1ns/1ns

module srec_knee_calc
    import srec_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        load_i,
    input  wire logic        hdr_i,
    input  wire logic        auto_i,
    input  wire logic [14:0] sw1_i,
    input  wire logic [14:0] sw2_i,
    input  wire logic [14:0] total_i,
    input  wire logic [3:0]  r2_i,
    input  wire logic [3:0]  r3_i,
    output srec_knee_s       knee_o
);

    // ------------------------------------------------------------
    // Interval selection
    // ------------------------------------------------------------
    wire logic [14:0] auto_t2  = total_i >> r2_i;
    wire logic [14:0] auto_t3  = total_i >> r3_i;
    wire logic [14:0] auto_t1  = sat_sub(sat_sub(total_i, auto_t2), auto_t3);
    wire logic [14:0] man_t2   = sat_sub(sw2_i, sw1_i);
    wire logic [14:0] man_t3   = sat_sub(total_i, sw2_i);

    srec_knee_s nxt_knee;
    assign nxt_knee = !hdr_i ? '{t1: total_i, t2: 15'h0000, t3: 15'h0000} :
                      auto_i ? '{t1: auto_t1, t2: auto_t2, t3: auto_t3} :
                               '{t1: sw1_i, t2: man_t2, t3: man_t3};

    srec_knee_s knee_ff;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            knee_ff <= '0;
        end else if (load_i) begin
            knee_ff <= nxt_knee;
        end
    end
    assign knee_o = knee_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_auto_second: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        load_i && hdr_i && auto_i |=> knee_o.t2 == ($past(total_i) >> $past(r2_i)))
        else $error("auto second interval wrong");

    a_manual_knee: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        load_i && hdr_i && !auto_i && sw2_i > sw1_i
        |=> knee_o.t1 == $past(sw1_i) && knee_o.t2 == $past(sw2_i) - $past(sw1_i))
        else $error("manual knee intervals wrong");

endmodule

/* verif/srec_trig_model.sv */
// Purpose: Trigger source on the pin side of the readout control
// Assumes: Pulses only when the bench asks for one
// Notes:   Pin rests low between pulses
`timescale 1ns/1ns
module srec_trig_model (
    input  wire logic clk_i,
    output logic      trig_o
);
    initial trig_o = 1'b0;
    task automatic pulse(input int hi);
        @(posedge clk_i);
        trig_o <= 1'b1;
        repeat (hi) @(posedge clk_i);
        trig_o <= 1'b0;
    endtask
endmodule

/* verif/tb_sensor_readout_exposure_control.sv */
// Purpose: Self-checking bench of the readout and exposure control
// Assumes: Row timing shortened through parameters
// Notes:   Register model is an array of masked writes
`timescale 1ns/1ns
module tb_sensor_readout_exposure_control
    import srec_pkg::*;
;
    logic        ref_clk, arst_n, wr, rd, trig, fs, fv, expo, pix_oe_n, sslave, fv_q, ovl;
    logic [7:0]  addr;
    logic [15:0] wdata, rdata, regs [256];
    logic [9:0]  pixel, pix, pix_q;
    logic [8:0]  row;
    logic [4:0]  mult;
    logic [1:0]  kph;
    int          fail_count, comparisons, seed, rows[$], exp_r[$], c[4];
    logic [15:0] modes [7] = '{16'h0188, 16'h0189, 16'h018A, 16'h018B,
                               16'h01E8, 16'h0108, 16'h0088};
    srec_core #(.ROW_CYCLES(8), .ACTIVE_ROWS(6), .VBLANK_ROWS(2), .ROW_START(9'h004))
    u_srec_core (.ref_clk_i(ref_clk), .arst_n_i(arst_n), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .trig_i(trig), .pixel_i(pixel), .pix_o(pix),
        .pix_oe_n_o(pix_oe_n), .row_addr_o(row), .frame_start_o(fs), .frame_valid_o(fv),
        .exposing_o(expo), .knee_phase_o(kph), .pll_mult_o(mult), .stereo_slave_o(sslave));
    srec_trig_model u_srec_trig_model (.clk_i(ref_clk), .trig_o(trig));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) pixel <= 10'($random(seed));
    always @(negedge ref_clk) begin
        if (fv_q) check(16'(pix), 16'(pix_q));
        if (fv && (rows.size() == 0 || rows[$] != row)) rows.push_back(int'(row));
        if (fv && expo) ovl = 1'b1;
        if (expo) c[kph]++;
        fv_q = fv;
        pix_q = pixel;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        print_verdict();
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] mask(input logic [7:0] a);
        case (a)
            ADDR_CTRL:                         return MSK_CTRL;
            ADDR_KNEE1, ADDR_KNEE2, ADDR_TOTAL: return MSK_ROW;
            ADDR_RATIO:                        return MSK_RATIO;
            ADDR_HDR:                          return MSK_HDR;
            default:                           return 16'h0000;
        endcase
    endfunction
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
        regs[a] = d & mask(a);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(negedge ref_clk);
        d = rdata;
    endtask
    task automatic rd_chk(input logic [7:0] a);
        logic [15:0] d;
        rd_reg(a, d);
        check(d, regs[a]);
    endtask
    task automatic wait_lvl(input logic v, input int lim, output int n);
        n = 0;
        while (expo !== v && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        check(16'(n < lim), 16'h0001);
    endtask
    task automatic wait_fs();
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (fs !== 1'b1 && n < 4000);
        check(16'(n < 4000), 16'h0001);
    endtask
    task automatic knee(input logic [15:0] rt, tot, input int t1, t2, t3);
        int n;
        wr_reg(ADDR_RATIO, rt);
        wr_reg(ADDR_TOTAL, tot);
        repeat (2) begin
            wait_lvl(1'b0, 2000, n);
            wait_lvl(1'b1, 2000, n);
        end
        c = '{0, 0, 0, 0};
        wait_lvl(1'b0, 2000, n);
        check(16'((c[1] + 4) / 8), 16'(t1));
        check(16'((c[2] + 4) / 8), 16'(t2));
        check(16'((c[3] + 4) / 8), 16'(t3));
    endtask
    task automatic trig_run(input int hi, input int lo, input int up);
        logic [15:0] st;
        int          n;
        do rd_reg(ADDR_STATUS, st); while ((st & 16'h0068) != 16'h0000);
        n = 0;
        repeat (40) begin
            @(negedge ref_clk);
            if (expo !== 1'b0) n++;
        end
        check(16'(n), 16'h0000);
        fork
            u_srec_trig_model.pulse(hi);
        join_none
        wait_lvl(1'b1, 5, n);
        wait_lvl(1'b0, 2000, n);
        check(16'(n >= lo && n <= up), 16'h0001);
        wait_fs();
    endtask
    task automatic print_verdict();
        $display("Counts: %0d mismatches, %0d comparisons", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        seed = 32'h7A454DF3;
        arst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
        foreach (regs[i]) regs[i] = 16'h0000;
        regs[ADDR_CTRL] = RST_CTRL;
        regs[ADDR_KNEE1] = RST_KNEE1;
        regs[ADDR_KNEE2] = RST_KNEE2;
        regs[ADDR_RATIO] = RST_RATIO;
        regs[ADDR_TOTAL] = RST_TOTAL;
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 256; i++) if (i != ADDR_STATUS) rd_chk(8'(i));
        repeat (8) begin
            wr_reg(ADDR_KNEE1, 16'($random(seed)));
            wr_reg(ADDR_KNEE2, 16'($random(seed)));
            wr_reg(8'h30, 16'($random(seed)));
            rd_chk(ADDR_KNEE1);
            rd_chk(ADDR_KNEE2);
            rd_chk(8'h30);
        end
        wr_reg(ADDR_TOTAL, 16'h0004);
        foreach (modes[m]) begin
            wr_reg(ADDR_CTRL, modes[m] | 16'hFE00);
            rd_chk(ADDR_CTRL);
            wait_fs();
            wait_fs();
            rows.delete();
            ovl = 1'b0;
            wait_fs();
            exp_r.delete();
            for (int i = 0; i < 6; i++) if (!modes[m][1] || i % 2 == 0) exp_r.push_back(4 + i);
            for (int i = 1; i < 6 && modes[m][2:0] == SCAN_TWO; i += 2) exp_r.push_back(4 + i);
            check(16'(rows.size()), 16'(exp_r.size()));
            foreach (exp_r[i]) check(16'(rows[i]), 16'(exp_r[i]));
            check(16'(mult), 16'(modes[m][5] ? MULT_STEREO : MULT_SOLO));
            check(16'(sslave), 16'(modes[m][5] & modes[m][6]));
            check(16'(pix_oe_n), 16'(!modes[m][7]));
            check(16'(ovl), 16'(modes[m][8]));
        end
        wr_reg(ADDR_HDR, 16'h0040);
        wr_reg(ADDR_KNEE1, 16'h0001);
        wr_reg(ADDR_KNEE2, 16'h0003);
        knee(16'h0004, 16'h0006, 1, 2, 3);
        knee(16'h0121, 16'h0008, 2, 4, 2);
        wr_reg(ADDR_TOTAL, 16'h0002);
        wr_reg(ADDR_CTRL, 16'h0198);
        trig_run(1, 9, 16);
        wr_reg(ADDR_CTRL, 16'h0180);
        trig_run(20, 18, 22);
        print_verdict();
    end
endmodule
